// ### verilog/pmc_cfg.svh
/*
  pmc_cfg.svh: offsets, field positions, mode codes, vector offsets,
  reset values and sizes of the processor mode control block.
  Assumes it is included by bare name; definitions only.
*/
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ==========================================================
// mode field codes
`define PMC_MODE_USER    5'h10
`define PMC_MODE_FIQ     5'h11
`define PMC_MODE_IRQ     5'h12
`define PMC_MODE_SVC     5'h13
`define PMC_MODE_ABT     5'h17
`define PMC_MODE_UND     5'h1b
`define PMC_MODE_SYS     5'h1f
`define PMC_NMODES       7

// ==========================================================
// status word layout
`define PMC_FLAGS_MSB    31
`define PMC_FLAGS_LSB    28
`define PMC_BIT_IRQ_MASK 7
`define PMC_BIT_FIQ_MASK 6
`define PMC_BIT_COMPACT  5
`define PMC_MODE_MSB     4
`define PMC_MODE_LSB     0

// ==========================================================
// register offsets
`define PMC_OFS_STATUS   8'h00
`define PMC_OFS_SAVED    8'h04
`define PMC_OFS_SP       8'h08
`define PMC_OFS_CTRL     8'h0c
`define PMC_OFS_WBUF     8'h10
`define PMC_OFS_MAC      8'h14
`define PMC_BIT_REFUSED  0
`define PMC_BIT_BIG_END  1
`define PMC_WBUF_ADDR_LSB 8

// ==========================================================
// exception vector offsets
`define PMC_VEC_RESET    8'h00
`define PMC_VEC_UNDEF    8'h04
`define PMC_VEC_SWI      8'h08
`define PMC_VEC_PABT     8'h0c
`define PMC_VEC_DABT     8'h10
`define PMC_VEC_IRQ      8'h18
`define PMC_VEC_FIQ      8'h1c

// ==========================================================
// reset values and sizes
`define PMC_RST_MODE     5'h13
`define PMC_RST_FLAGS    4'h0
`define PMC_WB_WORDS     16
`define PMC_WB_ADDRS     4

`endif

// ### verilog/pmc_pkg.sv
/*
  pmc_pkg: types of the processor mode control block.
  Assumes pmc_cfg.svh is on the include path.
*/
`include "pmc_cfg.svh"

package pmc_pkg;

  // ==========================================================
  // types
  typedef logic [4:0] pmc_mode_t;

  typedef enum logic [2:0] {
    PMC_EXC_NONE,
    PMC_EXC_DABT,
    PMC_EXC_FIQ,
    PMC_EXC_IRQ,
    PMC_EXC_PABT,
    PMC_EXC_UNDEF,
    PMC_EXC_SWI
  } pmc_exc_t;

  typedef struct packed {
    logic [3:0]                    flags;
    logic                          irq_mask;
    logic                          fiq_mask;
    logic                          compact;
    pmc_mode_t                     mode;
    logic                          privileged;
    logic [`PMC_NMODES-1:0][31:0]  sp_bank;
    logic [`PMC_NMODES-1:0][11:0]  saved_bank;
    logic [31:0]                   sp;
    logic [31:0]                   rdata;
    logic [31:0]                   mac_acc;
    logic                          exc_taken;
    logic [7:0]                    vector;
    logic [4:0]                    wb_words;
    logic [2:0]                    wb_addrs;
    logic                          wb_ready;
    logic                          refused;
  } pmc_state_t;

endpackage

// ### verilog/pmc_mac.sv
/*
  pmc_mac: combinational 32 x 16 signed multiply-accumulate.
  Assumes the caller registers the result, so one operation per cycle.
*/
module pmc_mac #(
  parameter int AW = 32, // multiplicand width
  parameter int BW = 16  // multiplier width
) (
  input  wire logic [AW-1:0] acc_in,  // running accumulator
  input  wire logic          clear,   // start from zero
  input  wire logic [AW-1:0] op_a,    // multiplicand
  input  wire logic [BW-1:0] op_b,    // multiplier
  output logic      [AW-1:0] result   // new accumulator
);

  logic signed [AW+BW-1:0] product;
  logic        [AW-1:0]    base;

  // ==========================================================
  // single-cycle multiply-accumulate, low word kept
  always_comb begin
    product = $signed(op_a) * $signed(op_b);
    base    = clear ? '0 : acc_in;
    result  = base + product[AW-1:0];
  end

endmodule

// ### verilog/pmc_core.sv
/*
  pmc_core: instruction state, operating mode, exception entry,
  banked stack pointers, write buffer occupancy and the MAC datapath.
  Assumes decode/execute logic and interrupt sources drive one-cycle
  event pulses (interrupt requests are levels) synchronous to clk,
  and a register master with one-cycle strobes.
*/
// Behaviour
// RULE1: two instruction states, 32-bit and 16-bit; only branch-exchange switches them.
// RULE2: seven modes: user, fast irq, irq, supervisor, abort, system, undefined.
// RULE3: user is the only unprivileged mode; all others are privileged.
// RULE4: software mode changes are honoured only from a privileged mode.
// RULE5: user reaches supervisor through the software interrupt instruction.
// RULE6: a taken normal interrupt enters normal interrupt mode.
// RULE7: a taken fast interrupt enters fast interrupt mode.
// RULE8: data abort or prefetch abort enters abort mode.
// RULE9: an undefined instruction enters undefined mode.
// RULE10: each mode has its own stack pointer, selected on entry.
// RULE11: write buffer holds up to 16 words and 4 addresses.
// RULE12: memory byte order is always little-endian, no big-endian option.
// RULE13: 32 by 16 multiply-accumulate completes in one cycle.
// RULE14: mode codes 10000,10001,10010,10011,10111,11011,11111.
// RULE15: bit 7 masks irq, bit 6 masks fast irq, bit 5 selects 16-bit state.
// RULE16: priority reset, data abort, fast irq, irq, prefetch abort, undef/swi.
// RULE17: software can read current mode and instruction state any time.
`include "pmc_cfg.svh"

module pmc_core
  import pmc_pkg::*;
#(
  parameter int WB_WORDS = `PMC_WB_WORDS, // write buffer data words
  parameter int WB_ADDRS = `PMC_WB_ADDRS  // write buffer addresses
) (
  input  wire logic        clk,             // core clock
  input  wire logic        nrst,            // async reset, active low
  input  wire logic [7:0]  reg_addr,        // register byte address
  input  wire logic [31:0] reg_wdata,       // register write data
  input  wire logic        reg_wr,          // register write strobe
  input  wire logic        reg_rd,          // register read strobe
  output logic      [31:0] reg_rdata,       // read data, cycle after strobe
  input  wire logic        irq_req,         // normal interrupt request level
  input  wire logic        fiq_req,         // fast interrupt request level
  input  wire logic        data_abort,      // data abort pulse
  input  wire logic        prefetch_abort,  // prefetch abort pulse
  input  wire logic        undef_instr,     // undefined encoding executed
  input  wire logic        swi_instr,       // software interrupt executed
  input  wire logic        bx_instr,        // branch-exchange executed
  input  wire logic        bx_to_compact,   // target state of branch-exchange
  input  wire logic        flags_wr,        // alu flags update
  input  wire logic [3:0]  flags_in,        // new alu flags
  input  wire logic        sp_wr,           // stack pointer write
  input  wire logic [31:0] sp_wdata,        // stack pointer value
  input  wire logic        wb_push,         // write word enters buffer
  input  wire logic        wb_push_new,     // pushed word opens an address
  input  wire logic        wb_pop_word,     // word drained to memory
  input  wire logic        wb_pop_addr,     // address entry retired
  input  wire logic        mac_en,          // multiply-accumulate step
  input  wire logic        mac_clear,       // accumulate from zero
  input  wire logic [31:0] mac_a,           // 32-bit operand
  input  wire logic [15:0] mac_b,           // 16-bit operand
  output logic      [4:0]  mode,            // current mode code
  output logic             compact_state,   // 16-bit instruction state
  output logic             privileged,      // privileged execution
  output logic             irq_mask,        // normal interrupts masked
  output logic             fiq_mask,        // fast interrupts masked
  output logic      [31:0] sp,              // stack pointer of current mode
  output logic             exc_taken,       // exception entry pulse
  output logic      [7:0]  exc_vector,      // vector offset of entry
  output logic      [3:0]  flags,           // alu flags
  output logic             wb_ready,        // write buffer can take a word
  output logic             big_endian,      // byte order, always little
  output logic      [31:0] mac_acc          // accumulator
);

  // ==========================================================
  // helpers
  function automatic logic mode_valid(input pmc_mode_t m);
    case (m)
      `PMC_MODE_USER, `PMC_MODE_FIQ, `PMC_MODE_IRQ, `PMC_MODE_SVC,
      `PMC_MODE_ABT, `PMC_MODE_UND, `PMC_MODE_SYS: mode_valid = 1'b1; // see RULE2
      default: mode_valid = 1'b0;
    endcase
  endfunction

  function automatic logic mode_priv(input pmc_mode_t m);
    mode_priv = (m != `PMC_MODE_USER); // see RULE3
  endfunction

  function automatic logic [2:0] mode_idx(input pmc_mode_t m);
    case (m)
      `PMC_MODE_FIQ: mode_idx = 3'h1;
      `PMC_MODE_IRQ: mode_idx = 3'h2;
      `PMC_MODE_SVC: mode_idx = 3'h3;
      `PMC_MODE_ABT: mode_idx = 3'h4;
      `PMC_MODE_UND: mode_idx = 3'h5;
      `PMC_MODE_SYS: mode_idx = 3'h6;
      default:       mode_idx = 3'h0;
    endcase
  endfunction

  function automatic logic [11:0] pack_short(input pmc_state_t s);
    pack_short = {s.flags, s.irq_mask, s.fiq_mask, s.compact, s.mode};
  endfunction

  function automatic logic [31:0] widen(input logic [11:0] w);
    widen = {w[11:8], 20'h0, w[7:0]};
  endfunction

  localparam logic [4:0] WB_WORDS_MAX = 5'(WB_WORDS);
  localparam logic [2:0] WB_ADDRS_MAX = 3'(WB_ADDRS);

  // ==========================================================
  // state
  pmc_state_t  st_ff;
  pmc_state_t  nxt_st;
  pmc_exc_t    exc;
  logic [31:0] mac_result;
  logic [2:0]  cur_idx;
  logic [11:0] pre_word;
  logic        push_ok;
  logic        push_new_ok;

  pmc_mac #(
    .AW (32),
    .BW (16)
  ) u_mac (
    .acc_in (st_ff.mac_acc),
    .clear  (mac_clear),
    .op_a   (mac_a),
    .op_b   (mac_b),
    .result (mac_result)
  );

  // ==========================================================
  // exception priority
  always_comb begin
    exc = PMC_EXC_NONE;
    if (data_abort) begin // see RULE16
      exc = PMC_EXC_DABT;
    end else if (fiq_req && !st_ff.fiq_mask) begin // see RULE15
      exc = PMC_EXC_FIQ;
    end else if (irq_req && !st_ff.irq_mask) begin // see RULE15
      exc = PMC_EXC_IRQ;
    end else if (prefetch_abort) begin
      exc = PMC_EXC_PABT;
    end else if (undef_instr) begin
      exc = PMC_EXC_UNDEF;
    end else if (swi_instr) begin
      exc = PMC_EXC_SWI;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.exc_taken = 1'b0;
    nxt_st.rdata     = 32'h0;
    cur_idx          = mode_idx(st_ff.mode);
    push_ok          = 1'b0;
    push_new_ok      = 1'b0;

    // software write of the status word
    if (reg_wr && reg_addr == `PMC_OFS_STATUS) begin
      nxt_st.flags = reg_wdata[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB];
      if (st_ff.privileged && mode_valid(reg_wdata[`PMC_MODE_MSB:`PMC_MODE_LSB])) begin // see RULE4
        nxt_st.mode     = reg_wdata[`PMC_MODE_MSB:`PMC_MODE_LSB];
        nxt_st.irq_mask = reg_wdata[`PMC_BIT_IRQ_MASK];
        nxt_st.fiq_mask = reg_wdata[`PMC_BIT_FIQ_MASK];
      end else if (reg_wdata[`PMC_MODE_MSB:`PMC_MODE_LSB] != st_ff.mode ||
                   reg_wdata[`PMC_BIT_IRQ_MASK] != st_ff.irq_mask ||
                   reg_wdata[`PMC_BIT_FIQ_MASK] != st_ff.fiq_mask) begin
        nxt_st.refused = 1'b1; // see RULE4
      end
      // state bit is not writable here; only branch-exchange moves it
    end

    // refused flag cleared by writing one
    if (reg_wr && reg_addr == `PMC_OFS_CTRL && reg_wdata[`PMC_BIT_REFUSED]) begin
      nxt_st.refused = 1'b0;
    end

    // alu flags from execute win over software
    if (flags_wr) begin
      nxt_st.flags = flags_in;
    end

    // stack pointer of the mode in force this cycle
    if (reg_wr && reg_addr == `PMC_OFS_SP) begin
      nxt_st.sp_bank[cur_idx] = reg_wdata; // see RULE10
    end
    if (sp_wr) begin
      nxt_st.sp_bank[cur_idx] = sp_wdata; // see RULE10
    end

    // instruction state change
    if (bx_instr) begin
      nxt_st.compact = bx_to_compact; // see RULE1
    end

    // exception entry overrides a same-cycle software mode write
    pre_word = pack_short(nxt_st);
    if (exc != PMC_EXC_NONE) begin
      nxt_st.exc_taken = 1'b1;
      nxt_st.irq_mask  = 1'b1;
      case (exc)
        PMC_EXC_DABT: begin
          nxt_st.mode   = `PMC_MODE_ABT; // see RULE8
          nxt_st.vector = `PMC_VEC_DABT;
        end
        PMC_EXC_FIQ: begin
          nxt_st.mode     = `PMC_MODE_FIQ; // see RULE7
          nxt_st.fiq_mask = 1'b1;
          nxt_st.vector   = `PMC_VEC_FIQ;
        end
        PMC_EXC_IRQ: begin
          nxt_st.mode   = `PMC_MODE_IRQ; // see RULE6
          nxt_st.vector = `PMC_VEC_IRQ;
        end
        PMC_EXC_PABT: begin
          nxt_st.mode   = `PMC_MODE_ABT; // see RULE8
          nxt_st.vector = `PMC_VEC_PABT;
        end
        PMC_EXC_UNDEF: begin
          nxt_st.mode   = `PMC_MODE_UND; // see RULE9
          nxt_st.vector = `PMC_VEC_UNDEF;
        end
        PMC_EXC_SWI: begin
          nxt_st.mode   = `PMC_MODE_SVC; // see RULE5
          nxt_st.vector = `PMC_VEC_SWI;
        end
        default: begin
          nxt_st.mode = st_ff.mode;
        end
      endcase
      nxt_st.saved_bank[mode_idx(nxt_st.mode)] = pre_word;
    end

    // derived views of the new mode
    nxt_st.privileged = mode_priv(nxt_st.mode); // see RULE3
    nxt_st.sp         = nxt_st.sp_bank[mode_idx(nxt_st.mode)]; // see RULE10

    // write buffer occupancy
    push_ok     = wb_push && st_ff.wb_ready;
    push_new_ok = push_ok && wb_push_new;
    if (push_ok && !(wb_pop_word && st_ff.wb_words != 5'h0)) begin
      nxt_st.wb_words = st_ff.wb_words + 5'h1; // see RULE11
    end else if (!push_ok && wb_pop_word && st_ff.wb_words != 5'h0) begin
      nxt_st.wb_words = st_ff.wb_words - 5'h1;
    end
    if (push_new_ok && !(wb_pop_addr && st_ff.wb_addrs != 3'h0)) begin
      nxt_st.wb_addrs = st_ff.wb_addrs + 3'h1; // see RULE11
    end else if (!push_new_ok && wb_pop_addr && st_ff.wb_addrs != 3'h0) begin
      nxt_st.wb_addrs = st_ff.wb_addrs - 3'h1;
    end
    // ready only when both a word and an address slot remain
    nxt_st.wb_ready = (nxt_st.wb_words < WB_WORDS_MAX) &&
                      (nxt_st.wb_addrs < WB_ADDRS_MAX); // see RULE11

    // multiply-accumulate
    if (mac_en) begin
      nxt_st.mac_acc = mac_result; // see RULE13
    end

    // register reads, answered from the current state
    if (reg_rd) begin
      case (reg_addr)
        `PMC_OFS_STATUS: begin
          nxt_st.rdata = widen(pack_short(st_ff)); // see RULE17
        end
        `PMC_OFS_SAVED: begin
          if (st_ff.mode != `PMC_MODE_USER && st_ff.mode != `PMC_MODE_SYS) begin
            nxt_st.rdata = widen(st_ff.saved_bank[cur_idx]);
          end
        end
        `PMC_OFS_SP: begin
          nxt_st.rdata = st_ff.sp;
        end
        `PMC_OFS_CTRL: begin
          nxt_st.rdata[`PMC_BIT_REFUSED] = st_ff.refused;
          nxt_st.rdata[`PMC_BIT_BIG_END] = 1'b0; // see RULE12
        end
        `PMC_OFS_WBUF: begin
          nxt_st.rdata[4:0] = st_ff.wb_words;
          nxt_st.rdata[`PMC_WBUF_ADDR_LSB +: 3] = st_ff.wb_addrs;
        end
        `PMC_OFS_MAC: begin
          nxt_st.rdata = st_ff.mac_acc;
        end
        default: begin
          nxt_st.rdata = 32'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // state register, reset acts as the reset exception
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff            <= '0;
      st_ff.mode       <= `PMC_RST_MODE; // see RULE14
      st_ff.flags      <= `PMC_RST_FLAGS;
      st_ff.irq_mask   <= 1'b1;
      st_ff.fiq_mask   <= 1'b1;
      st_ff.compact    <= 1'b0;
      st_ff.privileged <= 1'b1;
      st_ff.vector     <= `PMC_VEC_RESET;
      st_ff.wb_ready   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata     = st_ff.rdata;
  assign mode          = st_ff.mode;
  assign compact_state = st_ff.compact;  // see RULE15
  assign privileged    = st_ff.privileged;
  assign irq_mask      = st_ff.irq_mask;
  assign fiq_mask      = st_ff.fiq_mask;
  assign sp            = st_ff.sp;
  assign exc_taken     = st_ff.exc_taken;
  assign exc_vector    = st_ff.vector;
  assign flags         = st_ff.flags;
  assign wb_ready      = st_ff.wb_ready;
  assign big_endian    = st_ff.refused & 1'b0; // see RULE12
  assign mac_acc       = st_ff.mac_acc;

endmodule

// ### verification/pmc_core_sva.sv
/*
  pmc_core_sva: port assertions for pmc_core.
  Assumes it is bound to pmc_core, one clock, nrst active low.
*/
module pmc_core_sva (
  input wire logic        clk,            // core clock
  input wire logic        nrst,           // reset, low
  input wire logic        irq_req,        // irq level
  input wire logic        fiq_req,        // fiq level
  input wire logic        data_abort,     // event
  input wire logic        prefetch_abort, // event
  input wire logic        undef_instr,    // event
  input wire logic        swi_instr,      // event
  input wire logic        bx_instr,       // state switch
  input wire logic        bx_to_compact,  // target state
  input wire logic        mac_en,         // mac step
  input wire logic        mac_clear,      // mac from zero
  input wire logic [31:0] mac_a,          // operand
  input wire logic [15:0] mac_b,          // operand
  input wire logic [4:0]  mode,           // mode code
  input wire logic        compact_state,  // 16-bit state
  input wire logic        privileged,     // privileged
  input wire logic        irq_mask,       // irq masked
  input wire logic        fiq_mask,       // fiq masked
  input wire logic        exc_taken,      // entry pulse
  input wire logic [7:0]  exc_vector,     // vector
  input wire logic [31:0] mac_acc         // accumulator
);
  default clocking dclk @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic        fiq_go;
  logic        irq_go;
  logic        high_go;
  logic [31:0] mac_prod;
  assign fiq_go   = fiq_req & ~fiq_mask;
  assign irq_go   = irq_req & ~irq_mask;
  assign high_go  = data_abort | fiq_go | irq_go | prefetch_abort;
  assign mac_prod = $signed(mac_a) * $signed(mac_b);
  // ==========================================================
  // exception entry and priority
  chk_dabt_entry: assert property (data_abort |=> exc_taken && mode == 5'h17 && exc_vector == 8'h10)
    else $error("data abort entry wrong");
  chk_fiq_entry: assert property (fiq_go && !data_abort |=> mode == 5'h11 && irq_mask && fiq_mask)
    else $error("fast irq entry wrong");
  chk_irq_entry: assert property (irq_go && !data_abort && !fiq_go |=> mode == 5'h12 && exc_vector == 8'h18)
    else $error("irq entry wrong");
  chk_pabt_prio: assert property (prefetch_abort && !(data_abort | fiq_go | irq_go) |=> exc_vector == 8'h0c)
    else $error("prefetch abort priority wrong");
  chk_undef_entry: assert property (undef_instr && !high_go |=> mode == 5'h1b && exc_vector == 8'h04)
    else $error("undefined entry wrong");
  chk_swi_entry: assert property (swi_instr && !undef_instr && !high_go |=> mode == 5'h13 && exc_taken)
    else $error("swi entry wrong");
  // ==========================================================
  // mode, state and datapath
  chk_user_unpriv: assert property (privileged == (mode != 5'h10))
    else $error("privilege does not follow mode");
  chk_mode_legal: assert property (mode inside {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f})
    else $error("illegal mode code");
  chk_state_kept: assert property (!bx_instr |=> $stable(compact_state))
    else $error("state changed without bx");
  chk_bx_switch: assert property (bx_instr |=> compact_state == $past(bx_to_compact))
    else $error("bx target not taken");
  chk_mac_step: assert property (mac_en |=> mac_acc == ($past(mac_clear) ? 32'h0 : $past(mac_acc)) + $past(mac_prod))
    else $error("mac result wrong");
endmodule

bind pmc_core pmc_core_sva chk_u (.*);

// ### verification/pmc_evt_src.sv
/*
  pmc_evt_src: interrupt sources and decode side of pmc_core.
  Assumes the bench raises go for one cycle with a kind mask.
*/
module pmc_evt_src (
  input  wire logic       clk,            // core clock
  input  wire logic       nrst,           // async reset, low
  input  wire logic       go,             // command strobe
  input  wire logic [5:0] kind,           // fiq,irq,swi,undef,pabt,dabt
  input  wire logic [4:0] mode,           // core mode
  output logic            irq_req,        // irq level
  output logic            fiq_req,        // fiq level
  output logic            data_abort,     // pulse
  output logic            prefetch_abort, // pulse
  output logic            undef_instr,    // pulse
  output logic            swi_instr       // pulse
);
  logic [3:0] pulse_ff;
  logic       irq_ff;
  logic       fiq_ff;
  assign {swi_instr, undef_instr, prefetch_abort, data_abort} = pulse_ff;
  assign irq_req = irq_ff;
  assign fiq_req = fiq_ff;
  // ==========================================================
  // requests held until the serving mode shows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_ff <= 4'h0;
      irq_ff   <= 1'b0;
      fiq_ff   <= 1'b0;
    end else begin
      pulse_ff <= go ? kind[3:0] : 4'h0;
      irq_ff   <= (go & kind[4]) | (irq_ff & (mode != 5'h12));
      fiq_ff   <= (go & kind[5]) | (fiq_ff & (mode != 5'h11));
    end
  end
endmodule

// ### verification/tb_processor_mode_control.sv
/*
  tb_processor_mode_control: self-checking bench for pmc_core.
  Assumes pmc_evt_src drives exception inputs and the checker is bound.
*/
module tb_processor_mode_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic        bx_instr = 1'b0, bx_to_compact = 1'b0, wb_push = 1'b0, wb_push_new = 1'b0;
  logic        wb_pop = 1'b0, mac_en = 1'b0, mac_clear = 1'b0, sp_wr = 1'b0, flags_wr = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, mac_a = 32'h0, seed = 32'he681, acc = 32'h0;
  logic [15:0] mac_b = 16'h0;
  logic [5:0]  kind = 6'h0;
  logic [31:0] reg_rdata, sp, mac_acc;
  logic [31:0] spv [7];
  logic [4:0]  codes [7] = '{5'h13, 5'h11, 5'h12, 5'h17, 5'h1b, 5'h1f, 5'h10};
  logic [26:0] tbl [8] = '{{8'hdf, 6'h0f, 5'h17, 8'h10}, {8'hdf, 6'h0e, 5'h17, 8'h0c},
                           {8'hdf, 6'h0c, 5'h1b, 8'h04}, {8'hdf, 6'h08, 5'h13, 8'h08},
                           {8'hdf, 6'h10, 5'h1f, 8'h08}, {8'h1f, 6'h00, 5'h12, 8'h18},
                           {8'h1f, 6'h30, 5'h11, 8'h1c}, {8'h1f, 6'h00, 5'h12, 8'h18}};
  logic [7:0]  exc_vector;
  logic [4:0]  mode;
  logic [3:0]  flags;
  logic        compact_state, privileged, irq_mask, fiq_mask, exc_taken, wb_ready, big_endian;
  logic        irq_req, fiq_req, data_abort, prefetch_abort, undef_instr, swi_instr;
  int          n_errors = 0, check_count = 0;

  always #10 clk = ~clk;

  pmc_core dut_u (.flags_in(mac_b[3:0]), .sp_wdata(mac_a),
                  .wb_pop_word(wb_pop), .wb_pop_addr(wb_pop), .*);
  pmc_evt_src src_u (.*);

  // ==========================================================
  // expectations
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  function automatic logic [31:0] stat(input logic [4:0] m, input logic i, input logic f, input logic t);
    return {24'h0, i, f, t, m};
  endfunction
  function automatic logic [31:0] mac_next(input logic [31:0] a, input logic [15:0] b, input logic c,
                                           input logic [31:0] q);
    return (c ? 32'h0 : q) + 32'($signed(a) * $signed(b));
  endfunction

  // ==========================================================
  // drivers and checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, what);
  endtask
  task automatic ev(input logic [5:0] k);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic bx(input logic t);
    @(posedge clk);
    bx_instr <= 1'b1;
    bx_to_compact <= t;
    @(posedge clk);
    bx_instr <= 1'b0;
    #1 chk(compact_state, t, "state");
  endtask
  task automatic wb_fill(input int n, input logic all_new, input logic [31:0] exp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wb_push <= 1'b1;
      wb_push_new <= all_new || i == 0;
    end
    @(posedge clk);
    wb_push <= 1'b0;
    #1 chk(wb_ready, 32'h0, "buffer ready");
    rd(8'h10, exp, "buffer count");
    @(posedge clk);
    wb_pop <= 1'b1;
    repeat (16) @(posedge clk);
    wb_pop <= 1'b0;
    rd(8'h10, 32'h0, "buffer drained");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h00, stat(5'h13, 1'b1, 1'b1, 1'b0), "reset status");
    rd(8'h0c, 32'h0, "ctrl");
    chk(big_endian, 32'h0, "byte order");
    rd(8'h20, 32'h0, "unmapped");
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      spv[i] = seed;
      wr(8'h00, stat(codes[i], 1'b1, 1'b1, 1'b0));
      wr(8'h08, spv[i]);
    end
    ev(6'h08);
    chk(mode, 5'h13, "swi from user");
    rd(8'h04, 32'hd0, "saved status");
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, stat(codes[i], 1'b1, 1'b1, 1'b0));
      rd(8'h08, spv[i], "banked sp");
      chk(sp, spv[i], "sp port");
      chk(privileged, codes[i] != 5'h10, "privilege");
    end
    wr(8'h00, stat(5'h1f, 1'b1, 1'b1, 1'b0));
    rd(8'h00, stat(5'h10, 1'b1, 1'b1, 1'b0), "user change");
    rd(8'h0c, 32'h1, "refused flag");
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0, "refused cleared");
    bx(1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {24'h0, tbl[i][26:19]});
      ev(tbl[i][18:13]);
      chk(mode, tbl[i][12:8], "entry mode");
      chk(exc_vector, tbl[i][7:0], "entry vector");
      chk(compact_state, 32'h1, "state kept");
    end
    rd(8'h00, stat(5'h12, 1'b1, 1'b0, 1'b1), "irq status");
    bx(1'b0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      acc = mac_next(seed, seed[20:5], i == 0, acc);
      @(posedge clk);
      mac_en <= 1'b1;
      mac_clear <= (i == 0);
      mac_a <= seed;
      mac_b <= seed[20:5];
      @(posedge clk);
      mac_en <= 1'b0;
      #1 chk(mac_acc, acc, "mac");
    end
    @(posedge clk);
    sp_wr <= 1'b1;
    flags_wr <= 1'b1;
    @(posedge clk);
    sp_wr <= 1'b0;
    flags_wr <= 1'b0;
    #1 chk(sp, mac_a, "sp write");
    chk(flags, mac_b[3:0], "alu flags");
    wb_fill(20, 1'b0, 32'h0110);
    wb_fill(6, 1'b1, 32'h0404);
    tally_and_finish();
  end

  initial begin
    #100000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
